//--- gpio_pkg.sv
// Package: register indices, field positions and reset values of the two-port GPIO block
package gpio_pkg;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_UPPER_LEVELS = 4'h0;
  localparam logic [3:0] REG_UPPER_LATCH = 4'h1;
  localparam logic [3:0] REG_UPPER_DIR = 4'h2;
  localparam logic [3:0] REG_CTRL_LEVELS = 4'h3;
  localparam logic [3:0] REG_CTRL_LATCH = 4'h4;
  localparam logic [3:0] REG_CTRL_DIR = 4'h5;
  localparam logic [3:0] REG_NEIGHBOUR = 4'h6;
  localparam logic [3:0] REG_MEMCTRL = 4'h7;
  localparam int PULLUP_BIT = 5;
  localparam int BUS_DISABLE_BIT = 7;
  localparam int ADDR_PINS = 4;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] NEIGHBOUR_RST = 8'h00;
  localparam logic [7:0] MEMCTRL_RST = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

//--- pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module pin_sync
  import gpio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] level
);
  typedef struct packed {
    logic [PORT_W-1:0] s1;
    logic [PORT_W-1:0] s2;
    logic [PORT_W-1:0] s3;
    logic [PORT_W-1:0] lvl;
  } sync_t;
  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Only bits where stages two and three agree are taken
    st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 ^ st_r.s3));
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.lvl;
endmodule // pin_sync

//--- pin_mux.sv
// Per-pin output mux: peripheral override or latch under direction control
`timescale 1ns/1ps
module pin_mux
  import gpio_pkg::*;
(
  input wire logic [PORT_W-1:0] latch,
  input wire logic [PORT_W-1:0] dir,
  input wire logic [PORT_W-1:0] ovr_mask,
  input wire logic [PORT_W-1:0] ovr_data,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe
);
  // Override forces output; the stored direction bit is ignored, never altered
  assign pin_out = (ovr_mask & ovr_data) | (~ovr_mask & latch);
  assign pin_oe = ovr_mask | ~dir;
endmodule // pin_mux

//--- gpio_ports.sv
// Top: two 8-bit GPIO ports with external memory bus override and pull-ups
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Upper port: eight pins, own direction, latch
// - Direction 0 drives latch, 1 reads pin
// - Bus enabled: upper pins 0-3 carry address 16-19
// - Address pins forced output; pins 4-7 normal
// - Override ignores direction bits, leaves them stored
// - Control port: eight pins, own direction, latch
// - Control port resets to all inputs
// - Global bit 5 enables all control pull-ups
// - Output pins never get pull-ups
// - Pull-ups disabled after any reset
// - Clearing bus-disable bit makes control pins bus outputs
// - Bus mode forces all control pins driving
// - Control pins carry the eight bus strobes in order
module gpio_ports
  import gpio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] ext_address_high,
  input wire logic address_latch_enable,
  input wire logic output_enable,
  input wire logic write_low_byte_strobe,
  input wire logic write_high_byte_strobe,
  input wire logic byte_address_zero,
  input wire logic chip_enable,
  input wire logic lower_byte_enable,
  input wire logic upper_byte_enable,
  output logic ext_bus_enabled,
  input wire logic [PORT_W-1:0] upper_pin_in,
  output logic [PORT_W-1:0] upper_pin_out,
  output logic [PORT_W-1:0] upper_pin_oe,
  input wire logic [PORT_W-1:0] control_pin_in,
  output logic [PORT_W-1:0] control_pin_out,
  output logic [PORT_W-1:0] control_pin_oe,
  output logic [PORT_W-1:0] control_pin_pullup
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] upper_port_output_latch;
    logic [7:0] upper_port_direction;
    logic [7:0] control_port_output_latch;
    logic [7:0] control_port_direction;
    logic [7:0] neighbour_port_register;
    logic [7:0] memory_control_register;
    logic [7:0] rdata;
  } regs_t;
  // Read data is a register so software sees it one cycle after the strobe
  regs_t st_r;
  regs_t st_nxt;

  logic [PORT_W-1:0] upper_port_pin_levels;
  logic [PORT_W-1:0] control_port_pin_levels;
  logic bus_on;
  logic control_port_pullup_enable;
  logic [PORT_W-1:0] upper_ovr_mask;
  logic [PORT_W-1:0] upper_ovr_data;
  logic [PORT_W-1:0] ctrl_ovr_data;
  logic [PORT_W-1:0] ctrl_ovr_mask;
  logic wr_upper_latch;
  logic wr_upper_dir;
  logic wr_ctrl_latch;
  logic wr_ctrl_dir;
  logic wr_neighbour;
  logic wr_memctrl;

  // ************************************************************
  // Pin input sampling
  // ************************************************************
  // Four flops per pin (three stages plus the level); the level moves only once the last two stages agree
  pin_sync u_sync_upper (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(upper_pin_in),
    .level(upper_port_pin_levels)
  );

  pin_sync u_sync_ctrl (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(control_pin_in),
    .level(control_port_pin_levels)
  );

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // True when the index matches one register slot
  function automatic logic hits(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] idx
  );
    return addr == idx;
  endfunction

  // True when the index matches either of two register slots
  function automatic logic hits_either(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] idx_a,
    input logic [ADDR_W-1:0] idx_b
  );
    logic hit;
    hit = 1'b0;
    if (hits(addr, idx_a)) begin
      hit = 1'b1;
    end
    if (hits(addr, idx_b)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Stored byte, replaced by write data when its slot is hit
  function automatic logic [7:0] next_byte(
    input logic hit,
    input logic [7:0] wdata,
    input logic [7:0] old
  );
    logic [7:0] val;
    val = old;
    if (hit) begin
      val = wdata;
    end
    return val;
  endfunction

  // One read slot; unselected slots give zero so they can be or-ed
  function automatic logic [7:0] read_slot(
    input logic rd,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] idx,
    input logic [7:0] value
  );
    logic [7:0] val;
    val = ZERO_BYTE;
    if (rd && hits(addr, idx)) begin
      val = value;
    end
    return val;
  endfunction

  // Replicates one control bit across every pin of a port
  function automatic logic [PORT_W-1:0] spread(
    input logic bit_in
  );
    logic [PORT_W-1:0] val;
    val = '0;
    for (int i = 0; i < PORT_W; i++) begin
      val[i] = bit_in;
    end
    return val;
  endfunction

  // Marks the lowest count pins of a port when on is set
  function automatic logic [PORT_W-1:0] low_pins(
    input logic on,
    input int count
  );
    logic [PORT_W-1:0] val;
    val = '0;
    for (int i = 0; i < PORT_W; i++) begin
      if (i < count) begin
        val[i] = on;
      end
    end
    return val;
  endfunction

  // Pull-up only where the pin is released; a driven pin never needs it
  function automatic logic [PORT_W-1:0] pullup_mask(
    input logic enable,
    input logic [PORT_W-1:0] oe
  );
    logic [PORT_W-1:0] val;
    val = spread(enable) & ~oe;
    return val;
  endfunction

  // ************************************************************
  // Write decode
  // ************************************************************
  // Writing the pin-level index lands in the latch, so either index sets drive data
  assign wr_upper_latch = reg_write
    && hits_either(reg_addr, REG_UPPER_LEVELS, REG_UPPER_LATCH);
  assign wr_upper_dir = reg_write && hits(reg_addr, REG_UPPER_DIR);
  assign wr_ctrl_latch = reg_write
    && hits_either(reg_addr, REG_CTRL_LEVELS, REG_CTRL_LATCH);
  assign wr_ctrl_dir = reg_write && hits(reg_addr, REG_CTRL_DIR);
  assign wr_neighbour = reg_write && hits(reg_addr, REG_NEIGHBOUR);
  assign wr_memctrl = reg_write && hits(reg_addr, REG_MEMCTRL);

  // ************************************************************
  // Register file
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.upper_port_output_latch = next_byte(wr_upper_latch, reg_wdata,
      st_r.upper_port_output_latch);
    st_nxt.upper_port_direction = next_byte(wr_upper_dir, reg_wdata,
      st_r.upper_port_direction);
    st_nxt.control_port_output_latch = next_byte(wr_ctrl_latch, reg_wdata,
      st_r.control_port_output_latch);
    st_nxt.control_port_direction = next_byte(wr_ctrl_dir, reg_wdata,
      st_r.control_port_direction);
    st_nxt.neighbour_port_register = next_byte(wr_neighbour, reg_wdata,
      st_r.neighbour_port_register);
    st_nxt.memory_control_register = next_byte(wr_memctrl, reg_wdata,
      st_r.memory_control_register);
    // Unmapped indices hit no slot and so read back as zero
    st_nxt.rdata = read_slot(reg_read, reg_addr, REG_UPPER_LEVELS, upper_port_pin_levels)
      | read_slot(reg_read, reg_addr, REG_UPPER_LATCH, st_r.upper_port_output_latch)
      | read_slot(reg_read, reg_addr, REG_UPPER_DIR, st_r.upper_port_direction)
      | read_slot(reg_read, reg_addr, REG_CTRL_LEVELS, control_port_pin_levels)
      | read_slot(reg_read, reg_addr, REG_CTRL_LATCH, st_r.control_port_output_latch)
      | read_slot(reg_read, reg_addr, REG_CTRL_DIR, st_r.control_port_direction)
      | read_slot(reg_read, reg_addr, REG_NEIGHBOUR, st_r.neighbour_port_register)
      | read_slot(reg_read, reg_addr, REG_MEMCTRL, st_r.memory_control_register);
  end

  // Reset: control port all inputs, pull-up control off, bus disabled
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r.upper_port_output_latch <= LATCH_RST;
      st_r.upper_port_direction <= DIR_RST;
      st_r.control_port_output_latch <= LATCH_RST;
      st_r.control_port_direction <= DIR_RST;
      st_r.neighbour_port_register <= NEIGHBOUR_RST;
      st_r.memory_control_register <= MEMCTRL_RST;
      st_r.rdata <= ZERO_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Read back
  // ************************************************************
  // Zero except in the cycle after a read, so a bus can or several slaves together
  assign reg_rdata = st_r.rdata;

  // ************************************************************
  // External bus override
  // ************************************************************
  // Bus enable is decoded from the stored bit alone, so leaving bus mode
  // hands the pins straight back to their latch and direction bits
  assign bus_on = ~st_r.memory_control_register[BUS_DISABLE_BIT];
  assign ext_bus_enabled = bus_on;

  // Only the four address pins are taken; pins 4-7 stay ordinary I/O
  assign upper_ovr_mask = low_pins(bus_on, ADDR_PINS);
  // Data above the address field is never used, since those pins are not taken
  assign upper_ovr_data = {{(PORT_W - ADDR_PINS){1'b0}}, ext_address_high};

  // Pin order of the bus control outputs, lowest pin first
  assign ctrl_ovr_data[0] = address_latch_enable;
  assign ctrl_ovr_data[1] = output_enable;
  assign ctrl_ovr_data[2] = write_low_byte_strobe;
  assign ctrl_ovr_data[3] = write_high_byte_strobe;
  assign ctrl_ovr_data[4] = byte_address_zero;
  assign ctrl_ovr_data[5] = chip_enable;
  assign ctrl_ovr_data[6] = lower_byte_enable;
  assign ctrl_ovr_data[7] = upper_byte_enable;

  // Every control pin is taken as a whole; none is left to software
  assign ctrl_ovr_mask = spread(bus_on);

  // Upper port: only the address field is overridden
  pin_mux u_mux_upper (
    .latch(st_r.upper_port_output_latch),
    .dir(st_r.upper_port_direction),
    .ovr_mask(upper_ovr_mask),
    .ovr_data(upper_ovr_data),
    .pin_out(upper_pin_out),
    .pin_oe(upper_pin_oe)
  );

  // Control port: the whole port follows the bus while it is enabled
  pin_mux u_mux_ctrl (
    .latch(st_r.control_port_output_latch),
    .dir(st_r.control_port_direction),
    .ovr_mask(ctrl_ovr_mask),
    .ovr_data(ctrl_ovr_data),
    .pin_out(control_pin_out),
    .pin_oe(control_pin_oe)
  );

  // ************************************************************
  // Pull-ups
  // ************************************************************
  // Set bit enables; reset value clear keeps them off until software acts
  assign control_port_pullup_enable = st_r.neighbour_port_register[PULLUP_BIT];
  assign control_pin_pullup = pullup_mask(control_port_pullup_enable, control_pin_oe);
endmodule // gpio_ports

//--- gpio_ports_chk.sv
// Checker: port-level properties of the two-port GPIO block
`timescale 1ns/1ps
module gpio_ports_chk
  import gpio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] ext_address_high,
  input wire logic [7:0] ctl_in,
  input wire logic ext_bus_enabled,
  input wire logic [PORT_W-1:0] upper_pin_oe,
  input wire logic [PORT_W-1:0] upper_pin_out,
  input wire logic [PORT_W-1:0] control_pin_out,
  input wire logic [PORT_W-1:0] control_pin_oe,
  input wire logic [PORT_W-1:0] control_pin_pullup
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence latch_wr; reg_write && reg_addr == REG_UPPER_LATCH; endsequence
  sequence latch_rd; reg_read && reg_addr == REG_UPPER_LATCH; endsequence
  addr_pins_a:
    assert property (ext_bus_enabled |-> upper_pin_oe[3:0] == 4'hF
      && upper_pin_out[3:0] == ext_address_high) else $error("address pins wrong");
  ctrl_pins_a:
    assert property (ext_bus_enabled |-> control_pin_oe == 8'hFF
      && control_pin_out == ctl_in) else $error("control pins wrong");
  pullup_off_a:
    assert property ((control_pin_oe & control_pin_pullup) == 8'h00) else $error("pull-up on output");
  pullup_all_a:
    assert property (control_pin_pullup == 8'h00 || control_pin_pullup == ~control_pin_oe)
      else $error("pull-ups not uniform");
  reset_state_a:
    assert property ($fell(reset) |-> control_pin_oe == 8'h00 && control_pin_pullup == 8'h00
      && !ext_bus_enabled) else $error("bad state after reset");
  rdata_idle_a:
    assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("stray read data");
  latch_back_a:
    assert property (latch_wr ##2 latch_rd |=> reg_rdata == $past(reg_wdata, 3))
      else $error("latch readback wrong");
  unmapped_a:
    assert property (reg_read && reg_addr[3] |=> reg_rdata == 8'h00) else $error("unmapped read");
  dir_drive_a:
    assert property (reg_write && reg_addr == REG_UPPER_DIR && !ext_bus_enabled
      |=> upper_pin_oe == ~$past(reg_wdata)) else $error("direction not applied");
  bus_switch_a:
    assert property (reg_write && reg_addr == REG_MEMCTRL
      |=> ext_bus_enabled == !$past(reg_wdata[7])) else $error("bus enable wrong");
endmodule // gpio_ports_chk

//--- pin_board.sv
// Board model: resolves each pin from the port drive and an outside driver
`timescale 1ns/1ps
module pin_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_drive,
  output logic [7:0] pin_in
);
  // Outside driver holds every released pin, so no pin floats
  assign pin_in = (pin_out & pin_oe) | (ext_drive & ~pin_oe);
endmodule // pin_board

//--- gpio_ports_test.sv
// Testbench: register and pin traffic against a bench model
`timescale 1ns/1ps
bind gpio_ports gpio_ports_chk chk (.*, .ctl_in({upper_byte_enable, lower_byte_enable,
  chip_enable, byte_address_zero, write_high_byte_strobe, write_low_byte_strobe,
  output_enable, address_latch_enable}));
module gpio_ports_test;
  import gpio_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] ra = 4'h0, adh = 4'h0;
  logic [7:0] wd = 8'h00, ctl = 8'h00, ue = 8'h00, ce = 8'h00;
  logic we = 1'b0, re = 1'b0, bus;
  logic [7:0] rdata, uo, uoe, ui, co, coe, ci, cpu;
  int n_errors = 0, compares = 0, cyc = 0;
  int m[8];
  gpio_ports dut (.clk_sys, .reset, .reg_addr(ra), .reg_wdata(wd), .reg_write(we),
    .reg_read(re), .reg_rdata(rdata), .ext_address_high(adh),
    .address_latch_enable(ctl[0]), .output_enable(ctl[1]), .write_low_byte_strobe(ctl[2]),
    .write_high_byte_strobe(ctl[3]), .byte_address_zero(ctl[4]), .chip_enable(ctl[5]),
    .lower_byte_enable(ctl[6]), .upper_byte_enable(ctl[7]), .ext_bus_enabled(bus),
    .upper_pin_in(ui), .upper_pin_out(uo), .upper_pin_oe(uoe), .control_pin_in(ci),
    .control_pin_out(co), .control_pin_oe(coe), .control_pin_pullup(cpu));
  pin_board bu (.pin_out(uo), .pin_oe(uoe), .ext_drive(ue), .pin_in(ui));
  pin_board bc (.pin_out(co), .pin_oe(coe), .ext_drive(ce), .pin_in(ci));
  initial forever #2.5 clk_sys = ~clk_sys;
  // ****************
  // Bench model
  // ****************
  function automatic logic [7:0] eoe(bit c);
    bit b;
    b = m[7][7] == 0;
    return c ? (b ? 8'hFF : ~m[5]) : (~m[2] | (b ? 8'h0F : 8'h00));
  endfunction
  function automatic logic [7:0] eout(bit c);
    bit b;
    b = m[7][7] == 0;
    return c ? (b ? ctl : m[4]) : (b ? {m[1][7:4], adh} : m[1]);
  endfunction
  function automatic logic [7:0] lev(bit c);
    return (eoe(c) & eout(c)) | (~eoe(c) & (c ? ce : ue));
  endfunction
  task automatic chk(logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(int a, logic [7:0] d);
    @(posedge clk_sys);
    ra <= a[3:0];
    wd <= d;
    we <= 1'b1;
    @(posedge clk_sys);
    we <= 1'b0;
    if (a < 8) m[a == 0 ? 1 : a == 3 ? 4 : a] = d;
  endtask
  task automatic rd(int a);
    logic [7:0] e;
    e = a > 7 ? 0 : a == 0 ? lev(0) : a == 3 ? lev(1) : m[a];
    @(posedge clk_sys);
    ra <= a[3:0];
    re <= 1'b1;
    @(posedge clk_sys);
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic pins();
    chk(uoe, eoe(0));
    chk(uo & uoe, eout(0) & eoe(0));
    chk(coe, eoe(1));
    chk(co & coe, eout(1) & eoe(1));
    chk(cpu, m[6][5] ? ~eoe(1) : 8'h00);
    chk({7'h00, bus}, {7'h00, m[7][7] == 0});
  endtask
  // ****************
  // Hang guard: whole run needs well under this many cycles
  // ****************
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    int a;
    void'($urandom(32'h9790));
    m = '{0, 0, 255, 0, 0, 255, 0, 128};
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    #1 pins();
    for (a = 0; a < 10; a++) rd(a);
    $display("reset test done");
    wr(6, 8'h20);
    wr(7, 8'h00);
    #1 pins();
    rd(2);
    rd(5);
    wr(1, 8'hA5);
    rd(1);
    wr(7, 8'h80);
    #1 pins();
    $display("bus test done");
    repeat (60) begin
      wr($urandom % 9, $urandom);
      ue <= $urandom;
      ce <= $urandom;
      ctl <= $urandom;
      adh <= $urandom;
      repeat (6) @(posedge clk_sys);
      #1 pins();
      rd($urandom % 10);
    end
    $display("random test done");
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    m = '{0, 0, 255, 0, 0, 255, 0, 128};
    #1 pins();
    $display("second reset test done");
    test_done();
  end
endmodule // gpio_ports_test
